/* include/trig_params.svh */
// named constants for the breakpoint trigger response logic
// assumes inclusion by bare name from package and modules
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH
// register indices
`define ADDR_CONFIG_STATUS  4'h0
`define ADDR_TRIGGER_DEF    4'h1
`define ADDR_EXT_TRIGGER    4'h2
`define ADDR_PC_BP          4'h3
`define ADDR_PC_MASK        4'h4
`define ADDR_ADDR_LO        4'h5
`define ADDR_ADDR_HI        4'h6
`define ADDR_DATA_BP        4'h7
`define ADDR_DATA_MASK      4'h8
// config/status fields
`define CS_STAT_LSB         8
`define CS_FORCE_EMU_BIT    2
`define CS_TRACE_EMU_BIT    1
`define CS_MAP_BIT          0
// trigger definition fields
`define TD_RESP_LSB         0
`define TD_L1_PC_BIT        2
`define TD_L1_ADDR_BIT      3
`define TD_L1_DATA_BIT      4
`define TD_L2_PC_BIT        5
`define TD_L2_ADDR_BIT      6
`define TD_L2_DATA_BIT      7
`define TD_L2_OR_BIT        8
`define BST_NONE            4'h0
`define BST_WAIT1           4'h1
`define BST_HIT1            4'h2
`define BST_WAIT2           4'h5
`define BST_HIT2            4'h6
`define RESP_HALT           2'h1
`define RESP_DEBUG_IRQ      2'h2
`define PST_HALTED          4'hf
`define PST_EMU_ENTRY       4'hd
`define PST_EMU_EXIT        4'h7
`define VEC_NON_PC          8'h0c
`define VEC_PC              8'h0d
`define VEC_OFF_NON_PC      12'h030
`define VEC_OFF_PC          12'h034
// emulator address space
`define TT_EMU              2'h2
`define TM_EMU_DATA         3'h5
`define TM_EMU_PROG         3'h6
`define ENTRY_PST_CYCLES    3'h3
`endif

/* include/trig_pkg.sv */
// types for the breakpoint trigger response logic
// assumes trig_params.svh on the include path
`include "trig_params.svh"
package trig_pkg;
    typedef struct packed {
        logic        pc_hit;
        logic        addr_hit;
        logic        data_hit;
    } bp_hits_t;
    typedef struct packed {
        logic [1:0]  tt;
        logic [2:0]  tm;
        logic        cache_off;
    } emu_space_t;
    typedef enum logic [1:0] {
        LVL_IDLE  = 2'b00,
        LVL_WAIT1 = 2'b01,
        LVL_WAIT2 = 2'b10,
        LVL_DONE  = 2'b11
    } level_state_t;
    typedef enum logic [1:0] {
        CPU_RUN   = 2'b00,
        CPU_HALT  = 2'b01,
        CPU_ENTRY = 2'b10
    } cpu_state_t;
endpackage : trig_pkg

/* logic/bp_compare.sv */
// breakpoint comparators: pc with mask, address range, data with mask
// assumes bus values are same-clock signals from the core
`timescale 1ns/100ps
`default_nettype none
module bp_compare
    import trig_pkg::*;
#(
    parameter int W = 32
)(
    input  wire logic [W-1:0] pc,
    input  wire logic         pc_valid,
    input  wire logic [W-1:0] bus_addr,
    input  wire logic [W-1:0] bus_data,
    input  wire logic         bus_valid,
    input  wire logic [W-1:0] pc_ref,
    input  wire logic [W-1:0] pc_mask,
    input  wire logic [W-1:0] addr_lo,
    input  wire logic [W-1:0] addr_hi,
    input  wire logic [W-1:0] data_ref,
    input  wire logic [W-1:0] data_mask,
    output bp_hits_t          hits
);
    // mask bit set means that bit is ignored
    function automatic logic masked_eq(input logic [W-1:0] a, input logic [W-1:0] b,
                                       input logic [W-1:0] m);
        masked_eq = ((a ^ b) & ~m) == '0;
    endfunction : masked_eq

    wire logic in_range = (bus_addr >= addr_lo) && (bus_addr <= addr_hi);

    assign hits.pc_hit   = pc_valid && masked_eq(pc, pc_ref, pc_mask);
    assign hits.addr_hit = bus_valid && in_range;
    assign hits.data_hit = bus_valid && masked_eq(bus_data, data_ref, data_mask);
endmodule : bp_compare
`default_nettype wire

/* logic/emu_mode.sv */
// emulator mode state bit with exception save/restore
// assumes one-cycle event strobes from the core sequencer
`timescale 1ns/100ps
`default_nettype none
module emu_mode
    import trig_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic reset_exc_start,
    input  wire logic forced_emulator_bit,
    input  wire logic debug_exc_start,
    input  wire logic trace_exc_start,
    input  wire logic trace_force_emulation_bit,
    input  wire logic other_exc_start,
    input  wire logic rte_done,
    input  wire logic rte_fs1,
    output logic      emu,
    output logic      fault_status_bit1,
    output logic      emu_exit,
    output logic      emu_reenter
);
    logic emu_q, emu_d, fs1_q;

    // entry forced by reset, debug or trace; other exceptions drop it
    always_comb
    begin
        emu_d = emu_q;
        if (other_exc_start)
            emu_d = 1'b0;
        if (rte_done)
            emu_d = rte_fs1;
        if (reset_exc_start && forced_emulator_bit)
            emu_d = 1'b1;
        if (debug_exc_start)
            emu_d = 1'b1;
        if (trace_exc_start && trace_force_emulation_bit)
            emu_d = 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            emu_q <= 1'b0;
        else
            emu_q <= emu_d;
    end

    // saved copy goes into the stacked frame fault status
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            fs1_q <= 1'b0;
        else if (other_exc_start)
            fs1_q <= emu_q;
    end

    assign emu               = emu_q;
    assign fault_status_bit1 = fs1_q;
    assign emu_exit          = rte_done && emu_q && !rte_fs1;
    assign emu_reenter       = rte_done && rte_fs1;
endmodule : emu_mode
`default_nettype wire

/* logic/breakpoint_trigger_response.sv */
// breakpoint trigger response: levels, status, halt, debug interrupt
// assumes core strobes, bus views and register port all on clk
//
// Summary of operation
// - pc, address range and data breakpoints combine into one or two levels
// - registers written from serial port or debug write instruction; status readable
// - status nibble shown on trace port when idle; five documented codes
// - status read clears after level-2 hit, or level-1 hit with no level 2
// - any write to either trigger definition register clears status
// - pc breakpoints precise; address and data hits held pending
// - response 01 halts core, processor status shows 0xf
// - response 10 raises debug interrupt above level-7 request
// - debug interrupt pending until once-per-instruction sample point
// - recognised debug interrupt aborts, shows 0xd, enters emulator mode
// - eight-byte frame built first, then dedicated vector fetched
// - non-pc uses vector 12 offset 0x030, pc uses 13 offset 0x034
// - two-level vector follows last event; simultaneous pc and address picks 12
// - exception in emulator mode saves state, clears mode, sets stacked bit 17
// - return reloads saved bit; if set re-enters mode and shows 0xd
// - after return leaving emulator mode, breakpoints off for one instruction
// - forced emulator bit sampled only at start of reset exception processing
// - trace force bit enters emulator mode at trace exception start
// - map bit in emulator mode disables caches, forces type 2 modifier 5/6
// - return exits emulator mode; status 0xd on debug entry or re-entry, 0x7 on exit
// - unmasked interrupts still serviced in emulator mode
`timescale 1ns/100ps
`default_nettype none
`include "trig_params.svh"
module breakpoint_trigger_response
    import trig_pkg::*;
#(
    parameter int W = 32
)(
    input  wire logic         clk,
    input  wire logic         rst,
    // register port
    input  wire logic [3:0]   reg_addr,
    input  wire logic [W-1:0] reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic [W-1:0]      reg_rdata,
    // core views
    input  wire logic [W-1:0] pc,
    input  wire logic         pc_valid,
    input  wire logic [W-1:0] bus_addr,
    input  wire logic [W-1:0] bus_data,
    input  wire logic         bus_valid,
    input  wire logic         sample_point,
    input  wire logic         insn_done,
    input  wire logic         trace_busy,
    input  wire logic [3:0]   core_status,
    input  wire logic         irq_pending,
    input  wire logic         reset_exc_start,
    input  wire logic         trace_exc_start,
    input  wire logic         other_exc_start,
    input  wire logic         frame_done,
    input  wire logic         rte_done,
    input  wire logic         rte_fs1,
    input  wire logic         resume,
    // responses
    output logic              halt_req,
    output logic              debug_irq,
    output logic              debug_exc_start,
    output logic              vector_fetch,
    output logic [7:0]        vector_num,
    output logic [11:0]       vector_offset,
    output logic [3:0]        processor_status_code,
    output logic [3:0]        trace_status_data_port,
    output logic              emulator_mode,
    output logic              fault_status_bit1,
    output logic              service_irq,
    output emu_space_t        emu_space
);
    // ****************
    // registers
    // ****************
    logic [W-1:0] cfg_q, trigger_definition_q, extended_trigger_definition_q;
    logic [W-1:0] pc_ref_q, pc_mask_q, addr_lo_q, addr_hi_q, data_ref_q, data_mask_q;
    logic [3:0]   stat_q, stat_d;
    level_state_t lvl_q, lvl_d;
    cpu_state_t   cpu_q, cpu_d;
    logic         pend_q, pend_vec_pc_q, suppress_q;
    logic [W-1:0] rdata_q;
    logic [7:0]   vec_q;
    logic [2:0]   pst_cnt_q;
    logic [3:0]   pst_q;

    wire logic wr_cfg  = reg_wr && reg_addr == `ADDR_CONFIG_STATUS;
    wire logic wr_td   = reg_wr && reg_addr == `ADDR_TRIGGER_DEF;
    wire logic wr_xtd  = reg_wr && reg_addr == `ADDR_EXT_TRIGGER;
    wire logic rd_cfg  = reg_rd && reg_addr == `ADDR_CONFIG_STATUS;

    // writable from either master; only config/status reads back
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_q                         <= '0;
            trigger_definition_q          <= '0;
            extended_trigger_definition_q <= '0;
            pc_ref_q                      <= '0;
            pc_mask_q                     <= '0;
            addr_lo_q                     <= '0;
            addr_hi_q                     <= '0;
            data_ref_q                    <= '0;
            data_mask_q                   <= '0;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `ADDR_CONFIG_STATUS: cfg_q <= reg_wdata;
                `ADDR_TRIGGER_DEF:   trigger_definition_q <= reg_wdata;
                `ADDR_EXT_TRIGGER:   extended_trigger_definition_q <= reg_wdata;
                `ADDR_PC_BP:         pc_ref_q <= reg_wdata;
                `ADDR_PC_MASK:       pc_mask_q <= reg_wdata;
                `ADDR_ADDR_LO:       addr_lo_q <= reg_wdata;
                `ADDR_ADDR_HI:       addr_hi_q <= reg_wdata;
                `ADDR_DATA_BP:       data_ref_q <= reg_wdata;
                `ADDR_DATA_MASK:     data_mask_q <= reg_wdata;
                default:             ;
            endcase
        end
    end

    wire logic [1:0] trigger_response_code = trigger_definition_q[`TD_RESP_LSB +: 2];
    wire logic trace_force_emulation_bit = cfg_q[`CS_TRACE_EMU_BIT];
    wire logic forced_emulator_bit       = cfg_q[`CS_FORCE_EMU_BIT];
    wire logic map_bit                   = cfg_q[`CS_MAP_BIT];
    wire logic [W-1:0] cfg_view = {cfg_q[W-1:`CS_STAT_LSB + 4], stat_q,
                                   cfg_q[`CS_STAT_LSB-1:0]};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rd_cfg ? cfg_view : '0;
        end
    end
    assign reg_rdata = rdata_q;

    // ****************
    // comparators and level sequencing
    // ****************
    bp_hits_t hits;
    bp_compare #(.W(W)) u_cmp (
        .pc        (pc),
        .pc_valid  (pc_valid),
        .bus_addr  (bus_addr),
        .bus_data  (bus_data),
        .bus_valid (bus_valid),
        .pc_ref    (pc_ref_q),
        .pc_mask   (pc_mask_q),
        .addr_lo   (addr_lo_q),
        .addr_hi   (addr_hi_q),
        .data_ref  (data_ref_q),
        .data_mask (data_mask_q),
        .hits      (hits)
    );

    // enables per level: pc, address, data; data qualifies address
    function automatic logic level_hit(input bp_hits_t h, input logic en_pc,
                                       input logic en_a, input logic en_d, input logic use_or);
        logic ad;
        ad = (en_a || en_d) && (!en_a || h.addr_hit) && (!en_d || h.data_hit);
        if (use_or)
            level_hit = (en_pc && h.pc_hit) || ad;
        else
            level_hit = (en_pc || en_a || en_d) && (!en_pc || h.pc_hit)
                        && (en_a || en_d ? ad : 1'b1);
    endfunction : level_hit

    wire logic [W-1:0] td = trigger_definition_q;
    wire logic l1_en = td[`TD_L1_PC_BIT] | td[`TD_L1_ADDR_BIT] | td[`TD_L1_DATA_BIT];
    wire logic l2_en = td[`TD_L2_PC_BIT] | td[`TD_L2_ADDR_BIT] | td[`TD_L2_DATA_BIT];
    wire logic armed = !suppress_q;
    wire logic l1_hit = armed && level_hit(hits, td[`TD_L1_PC_BIT], td[`TD_L1_ADDR_BIT],
                                           td[`TD_L1_DATA_BIT], 1'b0);
    wire logic l2_hit = armed && level_hit(hits, td[`TD_L2_PC_BIT], td[`TD_L2_ADDR_BIT],
                                           td[`TD_L2_DATA_BIT], td[`TD_L2_OR_BIT]);
    // vector follows the final event; address wins a tie
    wire logic l2_nonpc = (td[`TD_L2_ADDR_BIT] || td[`TD_L2_DATA_BIT]) &&
                          (!td[`TD_L2_ADDR_BIT] || hits.addr_hit) &&
                          (!td[`TD_L2_DATA_BIT] || hits.data_hit);
    wire logic l1_nonpc = td[`TD_L1_ADDR_BIT] || td[`TD_L1_DATA_BIT];
    logic trig, trig_pc;

    always_comb
    begin
        lvl_d   = lvl_q;
        stat_d  = stat_q;
        trig    = 1'b0;
        trig_pc = 1'b0;
        case (lvl_q)
            LVL_IDLE:
            begin
                if (l1_en)
                begin
                    lvl_d  = LVL_WAIT1;
                    stat_d = `BST_WAIT1;
                end
            end
            LVL_WAIT1:
            begin
                if (l1_hit && l2_en)
                begin
                    lvl_d  = LVL_WAIT2;
                    stat_d = `BST_WAIT2;
                end
                else if (l1_hit)
                begin
                    lvl_d   = LVL_DONE;
                    stat_d  = `BST_HIT1;
                    trig    = 1'b1;
                    trig_pc = !l1_nonpc;
                end
            end
            LVL_WAIT2:
            begin
                if (l2_hit)
                begin
                    lvl_d   = LVL_DONE;
                    stat_d  = `BST_HIT2;
                    trig    = 1'b1;
                    trig_pc = !l2_nonpc;
                end
            end
            default: ;
        endcase
        if (rd_cfg && (stat_q == `BST_HIT2 || (stat_q == `BST_HIT1 && !l2_en)))
        begin
            stat_d = `BST_NONE;
            lvl_d  = LVL_IDLE;
        end
        if (wr_td || wr_xtd)
        begin
            stat_d = `BST_NONE;
            lvl_d  = LVL_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lvl_q  <= LVL_IDLE;
            stat_q <= `BST_NONE;
        end
        else
        begin
            lvl_q  <= lvl_d;
            stat_q <= stat_d;
        end
    end

    // ****************
    // response: halt or pending debug interrupt
    // ****************
    wire logic irq_trig  = trig && trigger_response_code == `RESP_DEBUG_IRQ;
    wire logic halt_trig = trig && trigger_response_code == `RESP_HALT;
    // taken at sample point; pc hit precedes its instruction
    wire logic take = (pend_q || irq_trig) && sample_point && cpu_q == CPU_RUN;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pend_q        <= 1'b0;
            pend_vec_pc_q <= 1'b0;
        end
        else if (take)
            pend_q <= 1'b0;
        else if (irq_trig)
        begin
            pend_q        <= 1'b1;
            pend_vec_pc_q <= trig_pc;
        end
    end

    wire logic cur_vec_pc = pend_q ? pend_vec_pc_q : trig_pc;
    assign debug_exc_start = take;
    // debug request outranks every level including 7
    assign service_irq = irq_pending && !take && !pend_q && cpu_q == CPU_RUN
                         && sample_point;

    always_comb
    begin
        cpu_d = cpu_q;
        case (cpu_q)
            CPU_RUN:
                if (halt_trig)
                    cpu_d = CPU_HALT;
                else if (take)
                    cpu_d = CPU_ENTRY;
            CPU_HALT:
                if (resume)
                    cpu_d = CPU_RUN;
            CPU_ENTRY:
                if (frame_done)
                    cpu_d = CPU_RUN;
            default:
                cpu_d = CPU_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_q <= CPU_RUN;
            vec_q <= `VEC_NON_PC;
        end
        else
        begin
            cpu_q <= cpu_d;
            if (take)
                vec_q <= cur_vec_pc ? `VEC_PC : `VEC_NON_PC;
        end
    end

    assign halt_req      = cpu_q == CPU_HALT;
    assign debug_irq     = pend_q;
    assign vector_fetch  = cpu_q == CPU_ENTRY && frame_done;
    assign vector_num    = vec_q;
    assign vector_offset = vec_q == `VEC_PC ? `VEC_OFF_PC : `VEC_OFF_NON_PC;

    // ****************
    // emulator mode and suppression after return
    // ****************
    logic emu_exit, emu_reenter;
    emu_mode u_emu (
        .clk                       (clk),
        .rst                       (rst),
        .reset_exc_start           (reset_exc_start),
        .forced_emulator_bit       (forced_emulator_bit),
        .debug_exc_start           (take),
        .trace_exc_start           (trace_exc_start),
        .trace_force_emulation_bit (trace_force_emulation_bit),
        .other_exc_start           (other_exc_start),
        .rte_done                  (rte_done),
        .rte_fs1                   (rte_fs1),
        .emu                       (emulator_mode),
        .fault_status_bit1         (fault_status_bit1),
        .emu_exit                  (emu_exit),
        .emu_reenter               (emu_reenter)
    );

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            suppress_q <= 1'b0;
        else if (emu_exit)
            suppress_q <= 1'b1;
        else if (insn_done)
            suppress_q <= 1'b0;
    end

    assign emu_space.cache_off = emulator_mode && map_bit;
    assign emu_space.tt = emu_space.cache_off ? `TT_EMU : 2'h0;
    assign emu_space.tm = emu_space.cache_off ? (pc_valid ? `TM_EMU_PROG : `TM_EMU_DATA)
                                              : 3'h0;

    // ****************
    // status outputs
    // ****************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pst_q     <= 4'h0;
            pst_cnt_q <= 3'h0;
        end
        else if (take || emu_reenter)
        begin
            pst_q     <= `PST_EMU_ENTRY;
            pst_cnt_q <= `ENTRY_PST_CYCLES;
        end
        else if (emu_exit)
        begin
            pst_q     <= `PST_EMU_EXIT;
            pst_cnt_q <= 3'h0;
        end
        else if (halt_trig || cpu_d == CPU_HALT)
        begin
            pst_q     <= `PST_HALTED;
            pst_cnt_q <= 3'h0;
        end
        else if (pst_cnt_q != 3'h0)
            pst_cnt_q <= pst_cnt_q - 3'h1;
        else
            pst_q <= core_status;
    end

    assign processor_status_code = pst_q;
    // status shown only while the trace port has nothing else
    wire logic [3:0] nib = {stat_q[2:0], 1'b0} | {stat_q[2], 3'h0};
    assign trace_status_data_port = trace_busy ? 4'h0 : nib;
endmodule : breakpoint_trigger_response
`default_nettype wire

/* dv/trig_properties.sv */
// port checker for the trigger response block
// assumes binding onto breakpoint_trigger_response
`timescale 1ns/100ps
`default_nettype none
module trig_props
    import trig_pkg::*;
#(parameter int W = 32)(
    input wire logic         clk,
    input wire logic         rst,
    input wire logic         reg_rd,
    input wire logic [W-1:0] reg_rdata,
    input wire logic         trace_busy,
    input wire logic         other_exc_start,
    input wire logic         rte_done,
    input wire logic         rte_fs1,
    input wire logic         halt_req,
    input wire logic         debug_exc_start,
    input wire logic         vector_fetch,
    input wire logic [7:0]   vector_num,
    input wire logic [11:0]  vector_offset,
    input wire logic [3:0]   processor_status_code,
    input wire logic [3:0]   trace_status_data_port,
    input wire logic         emulator_mode,
    input wire logic         fault_status_bit1,
    input wire logic         service_irq
);
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_entry;
        (processor_status_code == 4'hd && emulator_mode)[*3];
    endsequence
    a_entry_status: assert property (debug_exc_start |=> s_entry)
        else $error("entry status wrong");
    a_halt_shown: assert property (halt_req && $past(halt_req) |-> processor_status_code == 4'hf)
        else $error("halt status wrong");
    a_ret_exit: assert property (rte_done && emulator_mode && !rte_fs1 |=>
        !emulator_mode && processor_status_code == 4'h7)
        else $error("exit wrong");
    a_ret_reenter: assert property (rte_done && rte_fs1 |=>
        emulator_mode && processor_status_code == 4'hd)
        else $error("reentry wrong");
    a_nest_save: assert property (other_exc_start && emulator_mode |=>
        !emulator_mode && fault_status_bit1)
        else $error("nest save wrong");
    a_fetch_vec: assert property (vector_fetch |-> emulator_mode && (vector_num == 8'h0c ?
        vector_offset == 12'h030 : vector_num == 8'h0d && vector_offset == 12'h034))
        else $error("vector wrong");
    a_debug_first: assert property (debug_exc_start |-> !service_irq)
        else $error("irq beat debug");
    a_busy_quiet: assert property (trace_busy |-> trace_status_data_port == 4'h0)
        else $error("nibble while busy");
    a_nibble_legal: assert property (!trace_busy |->
        trace_status_data_port inside {4'h0, 4'h2, 4'h4, 4'ha, 4'hc})
        else $error("bad nibble");
    a_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("stray read data");
endmodule : trig_props
bind breakpoint_trigger_response trig_props #(.W(W)) u_trig_props (.clk, .rst, .reg_rd,
    .reg_rdata, .trace_busy, .other_exc_start, .rte_done, .rte_fs1, .halt_req,
    .debug_exc_start, .vector_fetch, .vector_num, .vector_offset, .processor_status_code,
    .trace_status_data_port, .emulator_mode, .fault_status_bit1, .service_irq);
`default_nettype wire

/* dv/dev_host_model.sv */
// development system side: register writes and status reads
// assumes the plain register port, one cycle read latency
`timescale 1ns/100ps
`default_nettype none
module dev_host_model (
    input  wire logic        clk,
    output logic [3:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    // ****************
    // bus cycles
    // ****************
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
endmodule : dev_host_model
`default_nettype wire

/* dv/breakpoint_trigger_response_test.sv */
// self-checking bench for the trigger response block
// assumes trig_pkg compiled first
`timescale 1ns/100ps
`default_nettype none
module breakpoint_trigger_response_test;
    import trig_pkg::*;
    logic clk = 0, rst = 1, pc_valid = 0, bus_valid = 0, trace_busy = 0, rte_fs1 = 0;
    logic [5:0] pv = '0;
    logic reg_wr, reg_rd, halt_req, debug_irq, debug_exc_start, vector_fetch;
    logic emulator_mode, fault_status_bit1, service_irq;
    logic [31:0] pc = 0, bus_addr = 0, reg_wdata, reg_rdata, rd_val, ref_pc, lo;
    logic [3:0] core_status = 0, reg_addr, processor_status_code, trace_status_data_port;
    logic [7:0] vector_num;
    logic [11:0] vector_offset;
    emu_space_t emu_space;
    int mismatches = 0, n_checks = 0;
    always #20 clk = ~clk;
    dev_host_model u_dev_host_model (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    breakpoint_trigger_response u_breakpoint_trigger_response (.clk, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pc, .pc_valid, .bus_addr, .bus_data('0),
        .bus_valid, .sample_point(pv[0]), .insn_done(pv[1]), .trace_busy, .core_status,
        .irq_pending(1'b0), .reset_exc_start(1'b0), .trace_exc_start(1'b0),
        .other_exc_start(pv[2]), .frame_done(pv[3]), .rte_done(pv[4]), .rte_fs1,
        .resume(pv[5]), .halt_req, .debug_irq, .debug_exc_start, .vector_fetch,
        .vector_num, .vector_offset, .processor_status_code, .trace_status_data_port,
        .emulator_mode, .fault_status_bit1, .service_irq, .emu_space);
    // ****************
    // helpers and sequence
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(input int i);
        @(posedge clk);
        pv[i] <= 1'b1;
        @(posedge clk);
        pv[i] <= 1'b0;
        #1;
    endtask : pulse
    task automatic finish_test;
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (4000) @(posedge clk);
        mismatches++;
        finish_test;
    end
    initial
    begin
        rd_val = $urandom(32'h9e2c0ae5);
        ref_pc = $urandom;
        lo = $urandom & 32'h7fff_ffff;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        u_dev_host_model.wr(4'h0, 32'h1);
        u_dev_host_model.wr(4'h3, ref_pc);
        u_dev_host_model.wr(4'h4, 32'h0);
        u_dev_host_model.wr(4'h1, 32'h5);
        u_dev_host_model.rd(4'h0, rd_val);
        chk(rd_val, 32'h101);
        chk(trace_status_data_port, 4'h2);
        pc <= ref_pc;
        pc_valid <= 1'b1;
        repeat (3) @(posedge clk);
        pc_valid <= 1'b0;
        #1 chk(halt_req, 1'b1);
        u_dev_host_model.rd(4'h0, rd_val);
        chk(rd_val, 32'h201);
        u_dev_host_model.rd(4'h0, rd_val);
        chk(rd_val, 32'h101);
        pulse(5);
        chk(halt_req, 1'b0);
        trace_busy <= 1'b1;
        core_status <= 4'($urandom);
        @(posedge clk);
        #1 chk(trace_status_data_port, 4'h0);
        trace_busy <= 1'b0;
        u_dev_host_model.wr(4'h5, lo);
        u_dev_host_model.wr(4'h6, lo + 32'h40);
        u_dev_host_model.wr(4'h1, 32'ha);
        bus_addr <= lo + ($urandom & 32'h3f);
        bus_valid <= 1'b1;
        repeat (3) @(posedge clk);
        bus_valid <= 1'b0;
        #1 chk(debug_irq, 1'b1);
        pulse(0);
        chk(emulator_mode, 1'b1);
        chk(vector_num, 8'h0c);
        chk(emu_space, 6'h2b);
        pv[3] <= 1'b1;
        #1 chk(vector_fetch, 1'b1);
        chk(vector_offset, 12'h030);
        @(posedge clk);
        pv[3] <= 1'b0;
        pulse(2);
        chk(fault_status_bit1, 1'b1);
        rte_fs1 <= 1'b1;
        pulse(4);
        chk(emulator_mode, 1'b1);
        rte_fs1 <= 1'b0;
        pulse(4);
        chk(processor_status_code, 4'h7);
        u_dev_host_model.wr(4'h1, 32'h6);
        pc_valid <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(debug_irq, 1'b0);
        pulse(1);
        repeat (2) @(posedge clk);
        #1 chk(debug_irq, 1'b1);
        pulse(0);
        chk(vector_num, 8'h0d);
        pulse(3);
        finish_test;
    end
endmodule : breakpoint_trigger_response_test
`default_nettype wire
